// File: rtl/rcb_pkg.sv
// Purpose: constants and types for the receive character buffer block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: register offsets are byte addresses
// Summary of operation
// - error summary bit 15 is OR of overrun, framing, parity bits 14..12
// - summary bit has no own clear; drops when all three flags clear
// - overrun bit 14 sets when a character loads while the previous is unserviced
// - on overrun the new character overwrites the unread old one
// - error flags clear on bus initialize, master reset and buffer read strobe
// - framing bit 13 sets when the character lacks a valid stop bit
// - framing flag only in isochronous mode, never in synchronous modes
// - with parity programmed, parity bit 12 sets on parity sense mismatch
// - parity flag stays clear while parity checking is not programmed
// - character sits right-justified from bit 0 for 5, 6, 7 or 8 bits
// - received parity bit goes in the next free bit above the character
// - 8-bit characters with parity do not show the parity bit
// - bus initialize or master reset sets the character byte to all ones
// - character byte is read-only; writes and read strobes never clear it
// - character-available sets on load; clears on initialize, reset, read strobe
// - mode bits: 11 internal sync, 10 external sync, 00 isochronous
package rcb_pkg;
  localparam int unsigned RCB_AW = 4;
  localparam logic [RCB_AW-1:0] RCB_OFS_RX_BUF = 4'h0;
  localparam logic [RCB_AW-1:0] RCB_OFS_PARAM = 4'h4;
  localparam logic [RCB_AW-1:0] RCB_OFS_IRQ_STAT = 4'h8;
  localparam logic [RCB_AW-1:0] RCB_OFS_IRQ_MASK = 4'hc;

  // receive character buffer fields
  localparam int unsigned RCB_BUF_ERR = 15;
  localparam int unsigned RCB_BUF_OVRN = 14;
  localparam int unsigned RCB_BUF_FRM = 13;
  localparam int unsigned RCB_BUF_PAR = 12;
  localparam logic [7:0] RCB_CHAR_RST = 8'hff;

  // parameter control fields
  localparam int unsigned RCB_PC_MODE_LO = 12;
  localparam int unsigned RCB_PC_WLEN_LO = 10;
  localparam int unsigned RCB_PC_PAR_EN = 9;
  localparam int unsigned RCB_PC_PAR_EVEN = 8;
  localparam logic [15:0] RCB_PC_RST = 16'h0000;

  // interrupt status and mask fields
  localparam int unsigned RCB_IRQ_W = 4;
  localparam int unsigned RCB_IRQ_AVAIL = 0;
  localparam int unsigned RCB_IRQ_OVRN = 1;
  localparam int unsigned RCB_IRQ_FRM = 2;
  localparam int unsigned RCB_IRQ_PAR = 3;
  localparam logic [RCB_IRQ_W-1:0] RCB_IRQ_RST = 4'h0;

  typedef enum logic [1:0] {
    RCB_MODE_ISO = 2'b00,
    RCB_MODE_BAD = 2'b01,
    RCB_MODE_EXT = 2'b10,
    RCB_MODE_INT = 2'b11
  } rcb_mode_t;

  typedef enum logic [1:0] {
    RCB_WLEN_5 = 2'b00,
    RCB_WLEN_6 = 2'b01,
    RCB_WLEN_7 = 2'b10,
    RCB_WLEN_8 = 2'b11
  } rcb_wlen_t;
endpackage : rcb_pkg

// File: rtl/rcb_reg_if.sv
// Purpose: register access strobes between bus front end and block core
// Assumes: single clock domain
// Notes: read strobe comes in the address phase, write in the data phase
`timescale 1ns/1ps
interface rcb_reg_if;
  import rcb_pkg::*;
  logic rd_stb;
  logic [RCB_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_stb;
  logic [RCB_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  modport port (output rd_stb, output rd_addr, input rd_data, output wr_stb, output wr_addr, output wr_data);
  modport core (input rd_stb, input rd_addr, output rd_data, input wr_stb, input wr_addr, input wr_data);
endinterface : rcb_reg_if

// File: rtl/rcb_char_fmt.sv
// Purpose: justify a framed character, place its parity bit, check parity
// Assumes: character bits arrive right-justified, bits above the length ignored
// Notes: purely combinational
`timescale 1ns/1ps
module rcb_char_fmt (
  input wire logic [7:0] i_bits,
  input wire logic i_par_bit,
  input wire rcb_pkg::rcb_wlen_t i_wlen,
  input wire logic i_par_en,
  input wire logic i_par_even,
  output logic [7:0] o_char,
  output logic o_par_bad
);
  import rcb_pkg::*;

  logic [3:0] len;
  logic [7:0] mask;
  logic ones;

  assign len = 4'h5 + {2'b00, i_wlen};

  always_comb begin
    mask = 8'h00;
    o_char = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < len) begin
        mask[i] = 1'b1;
        o_char[i] = i_bits[i];
      end else if (4'(i) == len && i_par_en) begin
        o_char[i] = i_par_bit;
      end
    end
    // len 8 leaves no slot, so the parity bit is dropped
  end

  assign ones = (^(i_bits & mask)) ^ i_par_bit;
  // even sense: total ones including parity must be even
  assign o_par_bad = i_par_en & (i_par_even ? ones : ~ones);
endmodule : rcb_char_fmt

// File: rtl/rcb_ahb_port.sv
// Purpose: AHB-Lite slave front end producing register strobes
// Assumes: single word transfers only, hsize not checked
// Notes: zero wait states; read data registered at the address phase edge
`timescale 1ns/1ps
module rcb_ahb_port (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  rcb_reg_if.port reg_bus
);
  import rcb_pkg::*;

  logic take;
  logic wr_pend;
  logic [RCB_AW-1:0] wr_addr;

  assign take = i_hsel & i_htrans[1] & i_hready;
  assign reg_bus.rd_stb = take & ~i_hwrite;
  assign reg_bus.rd_addr = i_haddr[RCB_AW-1:0];
  assign reg_bus.wr_stb = wr_pend;
  assign reg_bus.wr_addr = wr_addr;
  assign reg_bus.wr_data = i_hwdata;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= take & i_hwrite;
      if (take) begin
        wr_addr <= i_haddr[RCB_AW-1:0];
      end
    end
  end

  // sampling read data in the address phase keeps hrdata a flop with no wait
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (take & ~i_hwrite) begin
      o_hrdata <= reg_bus.rd_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end
endmodule : rcb_ahb_port

// File: rtl/rcb_top.sv
// Purpose: receive character buffer with error flags, parameter register and interrupt
// Assumes: framed characters arrive from a receiver shifter on the same clock
// Notes: reading the buffer word is the read strobe that clears the flags
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module rcb_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_bus_init,
  input wire logic i_char_load,
  input wire logic [7:0] i_char_bits,
  input wire logic i_char_par_bit,
  input wire logic i_char_stop_ok,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_char_avail,
  output rcb_pkg::rcb_mode_t o_mode,
  output rcb_pkg::rcb_wlen_t o_wlen,
  output logic [7:0] o_sync_char,
  output logic o_irq
);
  import rcb_pkg::*;

  rcb_reg_if reg_bus ();

  logic [7:0] received_character;
  logic overrun_flag;
  logic framing_flag;
  logic parity_flag;
  logic char_avail;
  logic [15:0] parameter_control;
  logic [RCB_IRQ_W-1:0] irq_status;
  logic [RCB_IRQ_W-1:0] irq_mask;
  logic [RCB_IRQ_W-1:0] irq_event;
  logic [RCB_IRQ_W-1:0] next_irq_status;

  logic buffer_read_strobe;
  logic init_any;
  logic [15:0] receive_character_buffer;
  logic [7:0] fmt_char;
  logic fmt_par_bad;
  logic par_en;
  logic par_even;
  logic frame_bad;
  logic ovrn_hit;
  rcb_mode_t mode;
  rcb_wlen_t wlen;

  // hsize is not decoded: only whole-word transfers are supported
  logic unused_hsize;
  assign unused_hsize = ^i_hsize;

  rcb_ahb_port u_port (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .reg_bus(reg_bus.port)
  );

  // parameter decode
  assign mode = rcb_mode_t'(parameter_control[RCB_PC_MODE_LO +: 2]);
  assign wlen = rcb_wlen_t'(parameter_control[RCB_PC_WLEN_LO +: 2]);
  assign par_en = parameter_control[RCB_PC_PAR_EN];
  assign par_even = parameter_control[RCB_PC_PAR_EVEN];

  rcb_char_fmt u_fmt (
    .i_bits(i_char_bits),
    .i_par_bit(i_char_par_bit),
    .i_wlen(wlen),
    .i_par_en(par_en),
    .i_par_even(par_even),
    .o_char(fmt_char),
    .o_par_bad(fmt_par_bad)
  );

  assign buffer_read_strobe = reg_bus.rd_stb && (reg_bus.rd_addr == RCB_OFS_RX_BUF);
  assign init_any = i_bus_init;

  // illegal mode 01 is treated as synchronous: no framing check
  assign frame_bad = (mode == RCB_MODE_ISO) && !i_char_stop_ok;
  // a read in the same cycle services the old character, so no overrun
  assign ovrn_hit = i_char_load && char_avail && !buffer_read_strobe;

  // character byte: only loads and reset actions change it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      received_character <= RCB_CHAR_RST;
    end else if (init_any) begin
      received_character <= RCB_CHAR_RST;
    end else if (i_char_load) begin
      received_character <= fmt_char;
    end
  end

  // character available: load wins over a same-cycle read strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      char_avail <= 1'b0;
    end else if (init_any) begin
      char_avail <= 1'b0;
    end else if (i_char_load) begin
      char_avail <= 1'b1;
    end else if (buffer_read_strobe) begin
      char_avail <= 1'b0;
    end
  end

  // overrun is sticky until a clearing action
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      overrun_flag <= 1'b0;
    end else if (init_any) begin
      overrun_flag <= 1'b0;
    end else if (ovrn_hit) begin
      overrun_flag <= 1'b1;
    end else if (buffer_read_strobe) begin
      overrun_flag <= 1'b0;
    end
  end

  // framing and parity describe the held character
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      framing_flag <= 1'b0;
      parity_flag <= 1'b0;
    end else if (init_any) begin
      framing_flag <= 1'b0;
      parity_flag <= 1'b0;
    end else if (i_char_load) begin
      framing_flag <= frame_bad;
      parity_flag <= fmt_par_bad && par_en;
    end else begin
      if (buffer_read_strobe) begin
        framing_flag <= 1'b0;
        parity_flag <= 1'b0;
      end
      if (!par_en) begin
        parity_flag <= 1'b0;
      end
    end
  end

  // parameter control is write-only; buffer writes are ignored
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      parameter_control <= RCB_PC_RST;
    end else if (reg_bus.wr_stb && reg_bus.wr_addr == RCB_OFS_PARAM) begin
      parameter_control <= reg_bus.wr_data[15:0];
    end
  end

  // interrupt events
  always_comb begin
    irq_event = '0;
    irq_event[RCB_IRQ_AVAIL] = i_char_load;
    irq_event[RCB_IRQ_OVRN] = ovrn_hit;
    irq_event[RCB_IRQ_FRM] = i_char_load && frame_bad;
    irq_event[RCB_IRQ_PAR] = i_char_load && fmt_par_bad;
  end

  // write-one-to-clear, a new event beats the clear
  always_comb begin
    next_irq_status = irq_status;
    if (reg_bus.wr_stb && reg_bus.wr_addr == RCB_OFS_IRQ_STAT) begin
      next_irq_status = irq_status & ~reg_bus.wr_data[RCB_IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_event;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_status <= RCB_IRQ_RST;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_mask <= RCB_IRQ_RST;
    end else if (reg_bus.wr_stb && reg_bus.wr_addr == RCB_OFS_IRQ_MASK) begin
      irq_mask <= reg_bus.wr_data[RCB_IRQ_W-1:0];
    end
  end

  // buffer word as software sees it
  always_comb begin
    receive_character_buffer = 16'h0000;
    receive_character_buffer[7:0] = received_character;
    receive_character_buffer[RCB_BUF_OVRN] = overrun_flag;
    receive_character_buffer[RCB_BUF_FRM] = framing_flag;
    // masked here too, so a read right after parity is turned off sees it clear
    receive_character_buffer[RCB_BUF_PAR] = parity_flag & par_en;
    // summary bit has no storage, so it cannot be cleared on its own
    receive_character_buffer[RCB_BUF_ERR] = overrun_flag | framing_flag | (parity_flag & par_en);
  end

  // read mux; unmapped and write-only words read zero
  always_comb begin
    reg_bus.rd_data = 32'h0000_0000;
    unique case (reg_bus.rd_addr)
      RCB_OFS_RX_BUF: reg_bus.rd_data = {16'h0000, receive_character_buffer};
      RCB_OFS_IRQ_STAT: reg_bus.rd_data = {28'h0000000, irq_status};
      RCB_OFS_IRQ_MASK: reg_bus.rd_data = {28'h0000000, irq_mask};
      default: reg_bus.rd_data = 32'h0000_0000;
    endcase
  end

  // registered outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_char_avail <= 1'b0;
      o_mode <= RCB_MODE_ISO;
      o_wlen <= RCB_WLEN_5;
      o_sync_char <= 8'h00;
      o_irq <= 1'b0;
    end else begin
      o_char_avail <= char_avail;
      o_mode <= mode;
      o_wlen <= wlen;
      o_sync_char <= parameter_control[7:0];
      o_irq <= |(irq_status & irq_mask);
    end
  end
endmodule : rcb_top

// File: test/rcb_char_src.sv
// Purpose: framed character source in place of the receiver shifter
// Assumes: one clock; loads change just after a rising edge
// Notes: data lines show the inverse of the last value between loads
`timescale 1ns/1ps
module rcb_char_src (
  input wire logic i_clk,
  output logic o_load,
  output logic [7:0] o_bits,
  output logic o_par,
  output logic o_stop
);
  initial begin
    o_load = 1'b0;
    o_bits = 8'h5a;
    o_par = 1'b0;
    o_stop = 1'b1;
  end

  task automatic send(input logic [7:0] b, input logic p, input logic s);
    @(posedge i_clk);
    o_load <= 1'b1;
    o_bits <= b;
    o_par <= p;
    o_stop <= s;
    @(posedge i_clk);
    o_load <= 1'b0;
    // stale data must not look valid
    o_bits <= ~b;
    o_par <= ~p;
    o_stop <= ~s;
  endtask : send
endmodule : rcb_char_src

// File: test/rcb_assertions.sv
// Purpose: port-level checks of the receive buffer flags
// Assumes: gaps between load and read as the bench makes them
// Notes: bound to rcb_top
`timescale 1ns/1ps
module rcb_assertions (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_bus_init,
  input wire logic i_char_load,
  input wire logic i_char_stop_ok,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_char_avail,
  input wire rcb_pkg::rcb_mode_t o_mode
);
  import rcb_pkg::*;
  logic rd_buf;
  logic clean;
  assign rd_buf = i_hsel && i_htrans[1] && i_hready && !i_hwrite && (i_haddr == 32'h0);
  assign clean = !rd_buf && !i_bus_init;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_ERR_SUMMARY: assert property (rd_buf |=> o_hrdata[15] == |o_hrdata[14:12])
    else $error("summary bit differs from flags");
  AST_ERR_DROPS: assert property (rd_buf && !i_char_load ##1 (!i_char_load && !rd_buf)[*2] ##1 rd_buf
    |=> o_hrdata[15:12] == 4'h0) else $error("flags survive a buffer read");
  AST_ZERO_GAP: assert property (rd_buf |=> o_hrdata[11:8] == 4'h0)
    else $error("unused buffer bits not zero");
  AST_OVERRUN: assert property (i_char_load && clean ##1 clean ##1 i_char_load && clean ##1 clean ##1 rd_buf
    |=> o_hrdata[14]) else $error("overrun not flagged");
  AST_FRAMING_SET: assert property (i_char_load && !i_char_stop_ok && o_mode == RCB_MODE_ISO && !i_bus_init
    ##1 clean ##1 rd_buf |=> o_hrdata[13]) else $error("framing flag missing");
  AST_FRAMING_SYNC: assert property (i_char_load && o_mode[1] && !i_bus_init ##1 clean ##1 rd_buf
    |=> !o_hrdata[13]) else $error("framing flag in synchronous mode");
  AST_INIT_ONES: assert property (i_bus_init ##1 !i_char_load ##1 rd_buf |=> o_hrdata[15:0] == 16'h00ff)
    else $error("initialize left byte or flags");
  AST_AVAIL_SET: assert property (i_char_load && !i_bus_init |-> ##2 o_char_avail)
    else $error("available flag not set");
  AST_AVAIL_CLEAR: assert property ((rd_buf || i_bus_init) && !i_char_load |-> ##2 !o_char_avail)
    else $error("available flag not cleared");

  cover property (rd_buf ##1 o_hrdata[14]);
  cover property (i_bus_init ##1 !i_char_load ##1 rd_buf);
  cover property (i_char_load && o_mode == RCB_MODE_ISO && !i_char_stop_ok);
endmodule : rcb_assertions

bind rcb_top rcb_assertions i_rcb_assertions (.i_clk(i_clk), .i_rst(i_rst), .i_bus_init(i_bus_init),
  .i_char_load(i_char_load), .i_char_stop_ok(i_char_stop_ok), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_char_avail(o_char_avail), .o_mode(o_mode));

// File: test/rcb_top_test.sv
// Purpose: self-checking bench for the receive buffer block
// Assumes: zero-wait bus, read notes queued and checked by a monitor
// Notes: hsize tied to word, hready fed back from hreadyout
`timescale 1ns/1ps
module rcb_top_test;
  import rcb_pkg::*;
  logic i_clk, i_rst, i_bus_init, i_hsel, i_hwrite, rd_dp, ld, par, stp;
  logic o_hreadyout, o_hresp, o_char_avail, o_irq;
  logic [1:0] i_htrans;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rng;
  logic [7:0] bits, o_sync_char;
  rcb_mode_t o_mode;
  rcb_wlen_t o_wlen;
  logic [31:0] exp_q[$];
  int errors, check_count;

  rcb_char_src i_rcb_char_src (.i_clk(i_clk), .o_load(ld), .o_bits(bits), .o_par(par), .o_stop(stp));
  rcb_top i_rcb_top (.i_clk(i_clk), .i_rst(i_rst), .i_bus_init(i_bus_init), .i_char_load(ld),
    .i_char_bits(bits), .i_char_par_bit(par), .i_char_stop_ok(stp), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'b010), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_char_avail(o_char_avail),
    .o_mode(o_mode), .o_wlen(o_wlen), .o_sync_char(o_sync_char), .o_irq(o_irq));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd

  // {parity bad, expected byte}
  function automatic logic [8:0] fmt(input logic [7:0] b, input logic p, input logic [1:0] wl,
    input logic pen, input logic ev);
    logic [7:0] m;
    logic [7:0] c;
    m = 8'hff >> (3 - wl);
    c = b & m;
    if (pen && wl != 2'b11) begin
      c[5 + wl] = p;
    end
    return {pen && (^(b & m) ^ p ^ ~ev), c};
  endfunction : fmt

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 40);
    if (o_hreadyout !== 1'b1) begin
      errors++;
      final_report();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_haddr <= a;
    i_hwrite <= wr;
    wait_ready();
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= d;
    wait_ready();
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  // read results leave in data-phase order
  always @(posedge i_clk) begin
    if (rd_dp && o_hreadyout === 1'b1) begin
      check(o_hrdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hdeadbeef);
      check(o_hresp, 1'b0);
    end
    if (o_hreadyout === 1'b1) begin
      rd_dp <= i_hsel && i_htrans[1] && !i_hwrite;
    end
  end

  initial begin
    logic [31:0] r;
    logic [8:0] f;
    logic [1:0] md;
    logic frm;
    rng = 32'h20e3;
    i_rst = 1'b1;
    i_bus_init = 1'b0;
    i_hsel = 1'b0;
    i_htrans = 2'b00;
    i_haddr = 32'h0;
    i_hwrite = 1'b0;
    i_hwdata = 32'h0;
    errors = 0;
    check_count = 0;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(32'h0, 32'h000000ff);
    rd(32'h4, 32'h0);
    rd(32'h8, 32'h0);
    check(o_char_avail, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      // every mode code, illegal 01 included, meets every length and parity setting
      md = i[1:0] ^ i[3:2];
      bus(1'b1, 32'h4, {18'h0, md, i[1:0], i[3], i[2], r[7:0]});
      repeat (2) @(posedge i_clk);
      #1 check({o_mode, o_wlen, o_sync_char}, {md, i[1:0], r[7:0]});
      i_rcb_char_src.send(r[15:8], r[16], r[17]);
      frm = (md == 2'b00) && !r[17];
      f = fmt(r[15:8], r[16], i[1:0], i[3], i[2]);
      rd(32'h0, {16'h0, frm | f[8], 1'b0, frm, f[8], 4'h0, f[7:0]});
      rd(32'h0, {24'h0, f[7:0]});
      check(o_char_avail, 1'b0);
    end
    $display("test formats done");
    bus(1'b1, 32'h4, 32'h00000c00);
    i_rcb_char_src.send(8'h3c, 1'b0, 1'b1);
    i_rcb_char_src.send(8'hc3, 1'b0, 1'b1);
    check(o_char_avail, 1'b1);
    rd(32'h0, 32'h0000c0c3);
    rd(32'h0, 32'h000000c3);
    $display("test overrun done");
    i_rcb_char_src.send(8'h00, 1'b0, 1'b0);
    @(posedge i_clk);
    i_bus_init <= 1'b1;
    @(posedge i_clk);
    i_bus_init <= 1'b0;
    rd(32'h0, 32'h000000ff);
    bus(1'b1, 32'h0, 32'h0);
    rd(32'h0, 32'h000000ff);
    $display("test initialize done");
    bus(1'b1, 32'h8, 32'hf);
    bus(1'b1, 32'hc, 32'h1);
    i_rcb_char_src.send(8'h11, 1'b0, 1'b1);
    @(posedge i_clk);
    #1 check(o_irq, 1'b1);
    rd(32'h8, 32'h1);
    bus(1'b1, 32'h8, 32'h1);
    repeat (2) @(posedge i_clk);
    #1 check(o_irq, 1'b0);
    bus(1'b1, 32'hc, 32'h0);
    i_rcb_char_src.send(8'h22, 1'b0, 1'b1);
    repeat (2) @(posedge i_clk);
    #1 check(o_irq, 1'b0);
    $display("test interrupt done");
    final_report();
  end
endmodule : rcb_top_test
